// >>> rtl/dfs_device.sv
/*
  Converter end: mixer, decimating filter, sync logic, output FIFO and
  lane serializer. Assumes the sample stream and the link pins are
  synchronous to i_ref_clk and that the far end drives the bit clock.
*/
// Functional notes
// [RL1] Complex decimation by 2, 4, 8, 16, 32
// [RL2] Low-pass, 85 dB stop, 0.8 pass band
// [RL3] Real decimation, half the complex bandwidth
// [RL4] Transition band centred on output Nyquist
// [RL5] Config bit turns pin into sync, clock-captured
// [RL6] Far end syncs whenever decimation is used
// [RL7] Sync resets dividers, aligns I and Q
// [RL8] Sync clears NCO phase, loads new frequency
// [RL9] Resync toggles spaced by multiples of 64
// [RL10] Complex lane, frame, bit clock rates
// [RL11] Real lane, frame, bit clock rates
// [RL12] Two, one and half lane at 18 bits
// [RL13] Far end restarts after new NCO word
// [RL14] Real mode bypasses mixer, low-pass only
// [RL15] Optional 6 dB complex, 3 dB real gain
// [RL16] Complex frame carries I then Q
// [RL17] Divider restarts the cycle after capture
`timescale 1ns/1ps
`default_nettype none
module dfs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic wr_en, rd_en;

  always_comb begin
    wr_en = i_in_valid & rdy_reg;
    rd_en = i_out_ready & (cnt_reg != '0);
    wr_next = wr_en ? ((wr_reg == LAST) ? '0 : PW'(wr_reg + 1'b1)) : wr_reg;
    rd_next = rd_en ? ((rd_reg == LAST) ? '0 : PW'(rd_reg + 1'b1)) : rd_reg;
    cnt_next = CW'(cnt_reg + CW'(wr_en) - CW'(rd_en));
    rdy_next = cnt_next != FULL;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else if (i_clk_en) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      if (wr_en) begin
        mem[wr_reg] <= i_in_data;
      end
    end
  end

  assign o_in_ready = rdy_reg;
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data = mem[rd_reg];
endmodule // dfs_fifo

module dfs_device (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Sample stream
  input wire logic i_samp_valid,
  input wire logic signed [dfs_pkg::DFS_SAMP_W-1:0] i_samp_data,
  output logic o_samp_ready,
  // Configuration
  input wire dfs_pkg::dfs_mode_t i_mode,
  input wire logic [2:0] i_log2n,
  input wire dfs_pkg::dfs_lane_t i_lane,
  input wire logic i_gain_en,
  input wire logic i_sync_en,
  input wire logic i_sw_sync,
  input wire logic i_mixer_restart,
  input wire logic [dfs_pkg::DFS_NCO_W-1:0] i_nco_freq,
  // Status
  output logic o_powered_down,
  output logic o_synced,
  // Link
  dfs_link_if.dev link
);
  import dfs_pkg::*;
  localparam int SW = DFS_SAMP_W;
  localparam int AW = DFS_ACC_W;

  function automatic logic signed [SW-1:0] mix(input logic signed [SW-1:0] x,
                                             input logic signed [9:0] t);
    logic signed [SW+9:0] p;
    p = x * t;
    return p[SW-1+DFS_TAB_FRAC:DFS_TAB_FRAC];
  endfunction

  // Optional gain, then saturate to the output width
  function automatic logic signed [SW-1:0] gain(input logic signed [AW-1:0] a,
                                              input logic cplx, input logic en);
    logic signed [AW+1:0] g;
    logic signed [AW+1:0] e;
    e = (AW+2)'(a);
    g = e;
    if (en && cplx) begin
      g = e <<< 1; // [RL15]
    end else if (en) begin
      g = e + (e >>> 2) + (e >>> 3) + (e >>> 4); // [RL15]
    end
    if (g > (AW+2)'(2 ** (SW - 1) - 1)) begin
      return {1'b0, {(SW-1){1'b1}}};
    end else if (g < -(AW+2)'(2 ** (SW - 1))) begin
      return {1'b1, {(SW-1){1'b0}}};
    end
    return g[SW-1:0];
  endfunction

  dfs_state_t st_reg, st_next;
  logic [DFS_NCO_W-1:0] phase_reg, phase_next, freq_reg, freq_next;
  logic [4:0] cnt_reg, cnt_next;
  logic signed [AW-1:0] acc_i_reg, acc_i_next, acc_q_reg, acc_q_next;
  logic signed [SW-1:0] hold_reg, hold_next;
  logic hold_v_reg, hold_v_next;
  logic pin_reg, pin_prev_reg, sync_pend_reg, sync_pend_next, synced_reg, synced_next;
  logic bclk_reg;
  logic [5:0] bit_reg, bit_next;
  logic [DFS_FRAME_W-1:0] sh_reg, sh_next;
  logic frame_reg, frame_next;
  logic [1:0] lane_reg, lane_next;
  logic fifo_rdy, fifo_out_v, pop, push_v, in_fire, last, cplx, edge_seen;
  logic [DFS_FRAME_W-1:0] push_d, fifo_out_d, word;
  logic signed [SW-1:0] mi, mq, gi, gq;
  logic signed [AW-1:0] sum_i, sum_q;
  logic [2:0] shamt;
  logic [4:0] n_m1;
  logic [5:0] len;

  always_comb begin
    cplx = i_mode == DFS_MODE_CPLX;
    st_next = (!i_sync_en && pin_reg) ? DFS_ST_PWRDN : DFS_ST_RUN; // [RL5]
    sync_pend_next = (i_sync_en & pin_reg & ~pin_prev_reg) | i_sw_sync; // [RL5]
    in_fire = i_samp_valid & fifo_rdy & (st_reg == DFS_ST_RUN);
    shamt = (i_mode == DFS_MODE_BYPASS) ? 3'h0 : i_log2n; // [RL1] [RL3]
    n_m1 = 5'((6'h01 << shamt) - 6'h01);
    last = cnt_reg == n_m1;
    // Mixer only in complex mode
    mi = cplx ? mix(i_samp_data, dfs_sin(phase_reg[31:29] + DFS_QUARTER_TURN)) : i_samp_data; // [RL14]
    mq = cplx ? mix(i_samp_data, dfs_sin(phase_reg[31:29])) : '0; // [RL14]
    // Accumulate-and-dump low-pass; band edges set by N [RL2] [RL4]
    sum_i = acc_i_reg + AW'(mi);
    sum_q = acc_q_reg + AW'(mq);
    gi = gain(sum_i >>> shamt, cplx, i_gain_en);
    gq = gain(sum_q >>> shamt, cplx, i_gain_en);
    phase_next = phase_reg;
    freq_next = freq_reg;
    cnt_next = cnt_reg;
    acc_i_next = acc_i_reg;
    acc_q_next = acc_q_reg;
    hold_next = hold_reg;
    hold_v_next = hold_v_reg;
    synced_next = synced_reg;
    push_v = 1'b0;
    push_d = '0;
    if (sync_pend_reg) begin
      phase_next = '0; // [RL8]
      freq_next = i_nco_freq; // [RL8]
      cnt_next = '0; // [RL7] [RL17]
      acc_i_next = '0; // [RL7]
      acc_q_next = '0;
      hold_v_next = 1'b0; // [RL7]
      synced_next = 1'b1;
    end else if (i_mixer_restart) begin
      phase_next = '0;
      freq_next = i_nco_freq;
    end else if (in_fire) begin
      if (cplx) begin
        phase_next = phase_reg + freq_reg;
      end
      if (last) begin
        cnt_next = '0;
        acc_i_next = '0;
        acc_q_next = '0;
        if (cplx) begin
          push_v = 1'b1;
          push_d = {gi, gq}; // [RL16]
        end else if (i_lane == DFS_LANE_TWO) begin
          push_v = hold_v_reg; // [RL11]
          push_d = {hold_reg, gi};
          hold_next = gi;
          hold_v_next = ~hold_v_reg;
        end else begin
          push_v = 1'b1;
          push_d = {gi, {SW{1'b0}}};
        end
      end else begin
        cnt_next = cnt_reg + 5'h01;
        acc_i_next = sum_i;
        acc_q_next = sum_q;
      end
    end
  end

  // Serializer: one bit per edge of the incoming bit clock
  always_comb begin
    len = dfs_frame_len(i_mode, i_lane); // [RL10] [RL11] [RL12]
    edge_seen = link.serial_bit_clock_input ^ bclk_reg;
    pop = edge_seen & ~sync_pend_reg & (st_reg == DFS_ST_RUN) & (bit_reg == '0) & i_clk_en;
    word = (bit_reg == '0) ? (fifo_out_v ? fifo_out_d : '0) : sh_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    frame_next = frame_reg;
    lane_next = lane_reg;
    if (sync_pend_reg) begin
      bit_next = '0; // [RL17]
      frame_next = 1'b0;
      lane_next = '0;
    end else if (edge_seen && st_reg == DFS_ST_RUN) begin
      frame_next = bit_reg < (len >> 1); // [RL10] [RL11]
      bit_next = (bit_reg >= len - 6'h01) ? '0 : bit_reg + 6'h01;
      if (i_lane == DFS_LANE_TWO) begin
        lane_next = {word[SW-1], word[DFS_FRAME_W-1]}; // [RL12]
        sh_next = {word[DFS_FRAME_W-2:SW], 1'b0, word[SW-2:0], 1'b0};
      end else begin
        lane_next = {1'b0, word[DFS_FRAME_W-1]}; // [RL12]
        sh_next = {word[DFS_FRAME_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_reg <= DFS_ST_RUN;
      phase_reg <= '0;
      freq_reg <= '0;
      cnt_reg <= '0;
      acc_i_reg <= '0;
      acc_q_reg <= '0;
      hold_reg <= '0;
      hold_v_reg <= 1'b0;
      pin_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      sync_pend_reg <= 1'b0;
      synced_reg <= 1'b0;
      bclk_reg <= 1'b0;
      bit_reg <= '0;
      sh_reg <= '0;
      frame_reg <= 1'b0;
      lane_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
      phase_reg <= phase_next;
      freq_reg <= freq_next;
      cnt_reg <= cnt_next;
      acc_i_reg <= acc_i_next;
      acc_q_reg <= acc_q_next;
      hold_reg <= hold_next;
      hold_v_reg <= hold_v_next;
      pin_reg <= link.align_pin; // [RL5]
      pin_prev_reg <= pin_reg;
      sync_pend_reg <= sync_pend_next;
      synced_reg <= synced_next;
      bclk_reg <= link.serial_bit_clock_input;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      frame_reg <= frame_next;
      lane_reg <= lane_next;
    end
  end

  dfs_fifo #(
    .WIDTH(DFS_FRAME_W),
    .DEPTH(DFS_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_in_valid(push_v),
    .i_in_data(push_d),
    .o_in_ready(fifo_rdy),
    .o_out_valid(fifo_out_v),
    .o_out_data(fifo_out_d),
    .i_out_ready(pop)
  );

  assign o_samp_ready = fifo_rdy;
  assign o_powered_down = st_reg == DFS_ST_PWRDN;
  assign o_synced = synced_reg;
  assign link.frame_clock = frame_reg;
  assign link.serial_bit_clock_output = bclk_reg; // [RL10]
  assign link.lane_data_outputs = lane_reg;
endmodule // dfs_device
`default_nettype wire

// >>> rtl/dfs_pkg.sv
/*
  Shared constants, types and helper functions of the decimation filter
  and its serial link. Assumes a single sampling clock for both ends.
*/
`default_nettype none
package dfs_pkg;
  localparam int DFS_SAMP_W = 18;
  localparam int DFS_NCO_W = 32;
  localparam int DFS_ACC_W = 24;
  localparam int DFS_FRAME_W = 36;
  localparam int DFS_FIFO_DEPTH = 4;
  localparam int DFS_LOG2N_MIN = 1;
  localparam int DFS_LOG2N_MAX = 5;
  localparam int DFS_TAB_FRAC = 9;
  localparam int DFS_RESYNC_W = 6;
  localparam logic [5:0] DFS_LEN_HALF_WORD = 6'h12;
  localparam logic [5:0] DFS_LEN_FULL_WORD = 6'h24;
  localparam logic [2:0] DFS_QUARTER_TURN = 3'h2;
  // Filter figures: stop band, pass band fractions, band centres for N = 4
  localparam int DFS_STOP_ATTEN_DB = 85;
  localparam real DFS_PASS_FRAC_CPLX = 0.8;
  localparam real DFS_PASS_FRAC_REAL = 0.4;
  localparam real DFS_N4_TRANS = 0.125;
  localparam real DFS_N4_ALIAS_TRANS = 0.375;
  localparam real DFS_N4_STOP = 0.25;

  typedef enum logic [2:0] {
    DFS_MODE_BYPASS = 3'b001,
    DFS_MODE_CPLX = 3'b010,
    DFS_MODE_REAL = 3'b100
  } dfs_mode_t;

  typedef enum logic [2:0] {
    DFS_LANE_TWO = 3'b001,
    DFS_LANE_ONE = 3'b010,
    DFS_LANE_HALF = 3'b100
  } dfs_lane_t;

  typedef enum logic [1:0] {
    DFS_ST_RUN = 2'b01,
    DFS_ST_PWRDN = 2'b10
  } dfs_state_t;

  // Eight-point sine, Q1.9
  function automatic logic signed [9:0] dfs_sin(input logic [2:0] ph);
    logic signed [9:0] v;
    v = 10'sh000;
    unique case (ph)
      3'h0: v = 10'sh000;
      3'h1: v = 10'sh16A;
      3'h2: v = 10'sh1FF;
      3'h3: v = 10'sh16A;
      3'h4: v = 10'sh000;
      3'h5: v = -10'sh16A;
      3'h6: v = -10'sh1FF;
      3'h7: v = -10'sh16A;
    endcase
    return v;
  endfunction

  // Bits per lane in one frame
  function automatic logic [5:0] dfs_frame_len(input dfs_mode_t m, input dfs_lane_t l);
    return (l == DFS_LANE_TWO || m != DFS_MODE_CPLX) ? DFS_LEN_HALF_WORD : DFS_LEN_FULL_WORD;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/dfs_link_if.sv
/*
  Serial link between the converter end and the receiving logic.
  Assumes both ends run on the same sampling clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dfs_link_if;
  logic align_pin;
  logic serial_bit_clock_input;
  logic frame_clock;
  logic serial_bit_clock_output;
  logic [1:0] lane_data_outputs;

  modport dev (
    input align_pin,
    input serial_bit_clock_input,
    output frame_clock,
    output serial_bit_clock_output,
    output lane_data_outputs
  );

  modport fpga (
    output align_pin,
    output serial_bit_clock_input,
    input frame_clock,
    input serial_bit_clock_output,
    input lane_data_outputs
  );
endinterface
`default_nettype wire

// >>> rtl/dfs_host.sv
/*
  Receiving end: drives the bit clock and the align pin, schedules sync
  pulses on a 64-cycle grid and rebuilds frames from the lanes.
  Assumes the converter end shares i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dfs_host (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Control
  input wire logic i_powerdown,
  input wire logic i_sync_req,
  input wire logic i_nco_changed,
  input wire dfs_pkg::dfs_mode_t i_mode,
  input wire dfs_pkg::dfs_lane_t i_lane,
  // Received words
  output logic [dfs_pkg::DFS_FRAME_W-1:0] o_word,
  output logic o_word_valid,
  output logic o_sync_pending,
  // Link
  dfs_link_if.fpga link
);
  import dfs_pkg::*;

  logic [DFS_RESYNC_W-1:0] tick_reg, tick_next;
  logic pend_reg, pend_next, pin_reg, pin_next, bclk_reg;
  logic sbco_reg, fprev_reg, fprev_next;
  logic [5:0] cnt_reg, cnt_next, len;
  logic [DFS_FRAME_W-1:0] acc_reg, acc_next, word_reg, word_next, base;
  logic wv_next, wv_reg, bit_v, start, two;

  always_comb begin
    tick_next = tick_reg + 1'b1;
    pend_next = pend_reg | i_sync_req | i_nco_changed; // [RL6] [RL13]
    pin_next = i_powerdown;
    if (pend_reg && tick_reg == '0) begin
      pin_next = 1'b1; // [RL9]
      pend_next = i_sync_req | i_nco_changed;
    end
    len = dfs_frame_len(i_mode, i_lane);
    two = i_lane == DFS_LANE_TWO;
    bit_v = link.serial_bit_clock_output ^ sbco_reg;
    start = link.frame_clock & ~fprev_reg;
    fprev_next = bit_v ? link.frame_clock : fprev_reg;
    base = start ? '0 : acc_reg;
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    wv_next = 1'b0;
    if (bit_v && (start || cnt_reg != '0)) begin
      if (two) begin
        acc_next = {base[DFS_FRAME_W-2:DFS_SAMP_W], link.lane_data_outputs[0],
                    base[DFS_SAMP_W-2:0], link.lane_data_outputs[1]};
      end else begin
        acc_next = {base[DFS_FRAME_W-2:0], link.lane_data_outputs[0]};
      end
      cnt_next = start ? 6'h01 : cnt_reg + 6'h01;
      if (cnt_next == len) begin
        word_next = (!two && len == DFS_LEN_HALF_WORD) ?
                    {acc_next[DFS_SAMP_W-1:0], {DFS_SAMP_W{1'b0}}} : acc_next;
        wv_next = 1'b1;
        cnt_next = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tick_reg <= '0;
      pend_reg <= 1'b0;
      pin_reg <= 1'b0;
      bclk_reg <= 1'b0;
      sbco_reg <= 1'b0;
      fprev_reg <= 1'b0;
      cnt_reg <= '0;
      acc_reg <= '0;
      word_reg <= '0;
      wv_reg <= 1'b0;
    end else if (i_clk_en) begin
      tick_reg <= tick_next;
      pend_reg <= pend_next;
      pin_reg <= pin_next;
      bclk_reg <= ~bclk_reg;
      sbco_reg <= link.serial_bit_clock_output;
      fprev_reg <= fprev_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      word_reg <= word_next;
      wv_reg <= wv_next;
    end
  end

  assign link.align_pin = pin_reg;
  assign link.serial_bit_clock_input = bclk_reg;
  assign o_word = word_reg;
  assign o_word_valid = wv_reg;
  assign o_sync_pending = pend_reg;
endmodule // dfs_host
`default_nettype wire

// >>> dv/dfs_monitor.sv
/*
  Checker of the serial link between the two ends of the decimation filter.
  Assumes one shared clock and frames of 18 bits per lane.
*/
`timescale 1ns/1ps
`default_nettype none
module dfs_monitor
  import dfs_pkg::*;
(
  // Clock, reset and control
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_sync_en,
  input wire logic i_sw_sync,
  input wire dfs_pkg::dfs_lane_t i_lane,
  // Link
  input wire logic align_pin,
  input wire logic serial_bit_clock_input,
  input wire logic frame_clock,
  input wire logic serial_bit_clock_output,
  input wire logic [1:0] lane_data_outputs
);
  logic [5:0] quiet_reg, quiet_next, gap_reg, gap_next;
  logic pin_reg, pin_next, seen_reg, seen_next;

  // Quiet window after any sync; gap since last align pulse
  always_comb begin
    quiet_next = (quiet_reg != 6'h00) ? quiet_reg - 6'h01 : 6'h00;
    if (align_pin || i_sw_sync) begin
      quiet_next = 6'h28;
    end
    pin_next = align_pin;
    gap_next = (align_pin && !pin_reg) ? 6'h00 : gap_reg + 6'h01;
    seen_next = seen_reg | (align_pin & ~pin_reg);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      quiet_reg <= 6'h00;
      gap_reg <= 6'h00;
      pin_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      quiet_reg <= quiet_next;
      gap_reg <= gap_next;
      pin_reg <= pin_next;
      seen_reg <= seen_next;
    end
  end

  sequence s_cleared;
    !frame_clock && (lane_data_outputs == 2'b00);
  endsequence

  sequence s_restart;
    s_cleared ##1 frame_clock;
  endsequence

  AST_BCLK_TOGGLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && i_clk_en |-> serial_bit_clock_input != $past(serial_bit_clock_input))
    else $error("bit clock input held still");

  AST_BCLK_ECHO: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_clk_en |-> serial_bit_clock_output == $past(serial_bit_clock_input))
    else $error("bit clock output does not follow input");

  AST_SYNC_CLEAR: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(align_pin) && i_sync_en |-> ##3 s_restart)
    else $error("sync did not restart the frame");

  AST_ALIGN_PULSE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(align_pin) && i_sync_en |=> !align_pin)
    else $error("sync pulse longer than one cycle");

  AST_SYNC_GRID: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    seen_reg && $rose(align_pin) && i_sync_en |-> gap_reg == 6'h3F)
    else $error("sync pulses off the 64 cycle grid");

  AST_FRAME_HIGH: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n || quiet_reg != 6'h00)
    $rose(frame_clock) |=> frame_clock [*8] ##1 !frame_clock)
    else $error("frame clock high run not 9 bits");

  AST_FRAME_LOW: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n || quiet_reg != 6'h00)
    $fell(frame_clock) |=> !frame_clock [*8] ##1 frame_clock)
    else $error("frame clock low run not 9 bits");

  AST_LANE1_IDLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_lane != DFS_LANE_TWO |-> lane_data_outputs[1] == 1'b0)
    else $error("second lane active outside two-lane mode");
endmodule // dfs_monitor
`default_nettype wire

// >>> dv/tb.sv
/*
  Testbench: both link ends back to back with the link checker beside them.
  Assumes the shared 200 MHz clock and one-hot mode and lane codes.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dfs_pkg::*;
  logic i_ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic samp_valid = 1'b0;
  logic signed [DFS_SAMP_W-1:0] samp_data = '0;
  dfs_mode_t mode = DFS_MODE_BYPASS;
  logic [2:0] log2n = 3'h1;
  dfs_lane_t lane = DFS_LANE_ONE;
  logic gain_en = 1'b0;
  logic sync_en = 1'b1;
  logic sw_sync = 1'b0;
  logic restart = 1'b0;
  logic [DFS_NCO_W-1:0] nco_freq = '0;
  logic powerdown = 1'b0;
  logic sync_req = 1'b0;
  logic nco_changed = 1'b0;
  logic samp_ready, powered_down, synced, word_valid, sync_pending, full_seen;
  logic [DFS_FRAME_W-1:0] word;
  logic [DFS_FRAME_W-1:0] got[$];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  dfs_link_if link();

  always #2.5 i_ref_clk = ~i_ref_clk;

  dfs_device u_dfs_device (.i_ref_clk(i_ref_clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_samp_valid(samp_valid), .i_samp_data(samp_data), .o_samp_ready(samp_ready),
    .i_mode(mode), .i_log2n(log2n), .i_lane(lane), .i_gain_en(gain_en),
    .i_sync_en(sync_en), .i_sw_sync(sw_sync), .i_mixer_restart(restart),
    .i_nco_freq(nco_freq), .o_powered_down(powered_down), .o_synced(synced), .link(link));
  dfs_host u_dfs_host (.i_ref_clk(i_ref_clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_powerdown(powerdown), .i_sync_req(sync_req), .i_nco_changed(nco_changed),
    .i_mode(mode), .i_lane(lane), .o_word(word), .o_word_valid(word_valid),
    .o_sync_pending(sync_pending), .link(link));
  dfs_monitor u_dfs_monitor (.i_ref_clk(i_ref_clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_sync_en(sync_en), .i_sw_sync(sw_sync), .i_lane(lane), .align_pin(link.align_pin),
    .serial_bit_clock_input(link.serial_bit_clock_input), .frame_clock(link.frame_clock),
    .serial_bit_clock_output(link.serial_bit_clock_output),
    .lane_data_outputs(link.lane_data_outputs));

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Received words, all-zero idle frames skipped; run limit
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (rst_n && word_valid === 1'b1 && word !== '0) begin
      got.push_back(word);
    end
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic check_word(input logic [DFS_FRAME_W-1:0] g, input logic [DFS_FRAME_W-1:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: word %h, expected %h", $time, g, e);
    end
  endtask

  task automatic check_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask

  task automatic check_count(input int g, input int e);
    compares++;
    if (g != e) begin
      fail_count++;
      $display("Error at %0t: count %0d, expected %0d", $time, g, e);
    end
  endtask

  task automatic start(input dfs_mode_t m, input logic [2:0] l2, input dfs_lane_t ln,
                       input logic se);
    rst_n = 1'b0;
    mode = m;
    log2n = l2;
    lane = ln;
    sync_en = se;
    tick(5);
    rst_n = 1'b1;
    got.delete();
  endtask

  task automatic do_sync(input logic by_nco);
    int k;
    k = 0;
    sync_req = !by_nco;
    nco_changed = by_nco;
    tick(1);
    sync_req = 1'b0;
    nco_changed = 1'b0;
    tick(1);
    while (sync_pending === 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    check_bit(sync_pending, 1'b0);
    tick(8);
  endtask

  task automatic send(input int n, input logic [DFS_SAMP_W-1:0] base,
                      input logic [DFS_SAMP_W-1:0] step);
    int k;
    logic r;
    k = 0;
    full_seen = 1'b0;
    samp_valid = 1'b1;
    while (k < n) begin
      samp_data = base + step * k[DFS_SAMP_W-1:0];
      r = samp_ready;
      tick(1);
      if (r === 1'b1) begin
        k++;
      end else begin
        full_seen = 1'b1;
      end
    end
    samp_valid = 1'b0;
  endtask

  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 3000) begin
      tick(1);
      k++;
    end
    tick(40);
    check_count(got.size(), n);
  endtask

  task automatic test_fill();
    start(DFS_MODE_BYPASS, 3'h1, DFS_LANE_ONE, 1'b1);
    send(8, 18'h00101, 18'h00011);
    check_bit(full_seen, 1'b1);
    wait_words(8);
    for (int i = 0; i < 8; i++) begin
      check_word(got[i], {18'h00101 + 18'h00011 * i[17:0], 18'h00000});
    end
  endtask

  task automatic real_case(input logic [2:0] l2, input dfs_lane_t ln, input logic g,
                           input int n, input logic [DFS_FRAME_W-1:0] e);
    start(DFS_MODE_REAL, l2, ln, 1'b1);
    gain_en = g;
    do_sync(1'b0);
    send(n, 18'h00400, 18'h00000);
    wait_words((ln == DFS_LANE_TWO) ? (n >> l2) / 2 : n >> l2);
    check_word(got[0], e);
    gain_en = 1'b0;
  endtask

  task automatic test_real();
    for (int l2 = 1; l2 <= 5; l2++) begin
      real_case(l2[2:0], DFS_LANE_ONE, 1'b0, 32, {18'h00400, 18'h00000});
    end
    real_case(3'h2, DFS_LANE_HALF, 1'b0, 16, {18'h00400, 18'h00000});
    real_case(3'h2, DFS_LANE_TWO, 1'b1, 16, {18'h005C0, 18'h005C0});
  endtask

  task automatic test_cplx();
    start(DFS_MODE_CPLX, 3'h2, DFS_LANE_TWO, 1'b1);
    gain_en = 1'b1;
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    do_sync(1'b1);
    do_sync(1'b0);
    check_bit(synced, 1'b1);
    send(16, 18'h00400, 18'h00000);
    wait_words(4);
    for (int i = 0; i < 4; i++) begin
      check_bit(got[i][17:0] === 18'h00000, 1'b1);
      check_bit(got[i][35:18] !== 18'h00000, 1'b1);
    end
    gain_en = 1'b0;
  endtask

  task automatic test_pwrdn();
    start(DFS_MODE_BYPASS, 3'h1, DFS_LANE_ONE, 1'b0);
    powerdown = 1'b1;
    tick(6);
    check_bit(powered_down, 1'b1);
    send(3, 18'h00123, 18'h00000);
    powerdown = 1'b0;
    tick(6);
    check_bit(powered_down, 1'b0);
    check_bit(synced, 1'b0);
    sw_sync = 1'b1;
    tick(1);
    sw_sync = 1'b0;
    tick(3);
    check_bit(synced, 1'b1);
    tick(100);
    check_count(got.size(), 0);
  endtask

  initial begin
    tick(1);
    test_fill();
    test_real();
    test_cplx();
    test_pwrdn();
    stop_test();
  end
endmodule // tb
`default_nettype wire
